// [core/swd_core.sv]
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module swd_core
   import swd_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Register port
   input  wire swd_bus_type  bus,
   output logic [15:0]       rdata,
   // Program sequencer strobes (same clock)
   input  wire swd_prog_type prog,
   // Diagnosis inputs from pins
   input  wire logic         io_mismatch_pin,
   input  wire logic         io_fail_pin,
   input  wire logic         cfg_mismatch_pin,
   input  wire logic         batt_low_pin,
   input  wire logic         hw_crit_pin,
   // Indications and control outputs
   output logic              run_enable,
   output logic              outputs_off,
   output logic              error_lamp,
   output logic              backup_cell_lamp,
   output logic              irq
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   wire  [4:0] pin_raw = {hw_crit_pin, batt_low_pin, cfg_mismatch_pin,
                          io_fail_pin, io_mismatch_pin};

   // Two flops per pin
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   wire io_bad   = pin_s2_q[0] | pin_s2_q[1];
   wire cfg_bad  = pin_s2_q[2];
   wire batt_low = pin_s2_q[3];
   wire hw_bad   = pin_s2_q[4];

   // ************************************************************
   // Registers
   // ************************************************************
   logic [2:0]        ctrl_q;
   logic [TMO_W-1:0]  tmo_q;
   logic [EV_N-1:0]   stat_q;
   logic [EV_N-1:0]   mask_q;
   logic [15:0]       err_code_q;
   logic [15:0]       min_code_q;
   logic [TMO_W:0]    wdt_cnt_q;
   logic [31:0]       tick_cnt_q;
   logic              tick_q;
   swd_state_type     state_q;
   swd_state_type     state_d;

   // Clamp a written timeout into the legal range
   function automatic logic [TMO_W-1:0] clamp_tmo(input logic [15:0] v);
      if (v < 16'(TMO_MIN_MS))
         clamp_tmo = TMO_W'(TMO_MIN_MS);
      else if (v > 16'(TMO_MAX_MS))
         clamp_tmo = TMO_W'(TMO_MAX_MS);
      else
         clamp_tmo = v[TMO_W-1:0];
   endfunction : clamp_tmo

   // Decodes
   wire wr_ctrl = bus.wr && (bus.addr == ADR_CTRL);
   wire wr_tmo  = bus.wr && (bus.addr == ADR_TMO);
   wire wr_stat = bus.wr && (bus.addr == ADR_STAT);
   wire wr_mask = bus.wr && (bus.addr == ADR_MASK);

   wire stop_mode = ctrl_q[CTL_STOP_MODE];
   wire man_rst   = wr_ctrl && bus.wdata[CTL_MAN_RESET];
   wire release_w = man_rst || stop_mode;
   wire running   = (state_q == ST_RUN);

   // ************************************************************
   // 1 ms tick divider
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q     <= 1'b0;
      end
   end

   // ************************************************************
   // Watchdog counter
   // ************************************************************
   wire wdt_restart = prog.scan_end || prog.wdt_clear;
   wire wdt_expire  = running && (wdt_cnt_q > {1'b0, tmo_q});

   // Restart, else count ticks while running
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         wdt_cnt_q <= '0;
      else if (!running || wdt_restart)
         wdt_cnt_q <= '0;
      else if (tick_q && !wdt_cnt_q[TMO_W])
         wdt_cnt_q <= wdt_cnt_q + 1'b1;
   end

   // ************************************************************
   // Fault classification
   // ************************************************************
   wire [EV_N-1:0] ev;
   assign ev[EV_WDT]    = wdt_expire;
   assign ev[EV_IOMOD]  = io_bad;
   assign ev[EV_CFG]    = cfg_bad;
   assign ev[EV_BATT]   = batt_low;
   assign ev[EV_HWCRIT] = hw_bad;
   assign ev[EV_ARITH]  = running && prog.arith_err;
   assign ev[EV_EXTCR]  = running && prog.ext_crit;
   assign ev[EV_EXTMN]  = running && prog.ext_minor;

   // Critical faults stop, the rest only warn
   wire crit = ev[EV_WDT] | ev[EV_IOMOD] | ev[EV_CFG] | ev[EV_HWCRIT]
             | ev[EV_EXTCR]
             | (ev[EV_ARITH] & ctrl_q[CTL_ARITH_STOP]);

   // Highest priority critical code
   wire [15:0] crit_code = ev[EV_WDT]    ? CODE_WDT   :
                           ev[EV_HWCRIT] ? CODE_HWCRIT :
                           ev[EV_IOMOD]  ? CODE_IOMOD :
                           ev[EV_CFG]    ? CODE_CFG   :
                           ev[EV_EXTCR]  ? CODE_EXTCR : CODE_ARITH;
   // Minor code
   wire [15:0] minor_code = ev[EV_BATT]  ? CODE_BATT  :
                            ev[EV_ARITH] ? CODE_ARITH :
                            ev[EV_EXTMN] ? CODE_EXTMN : CODE_NONE;
   wire minor = ev[EV_BATT] | ev[EV_ARITH] | ev[EV_EXTMN];

   // ************************************************************
   // Run state machine
   // ************************************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (!stop_mode && crit)
               state_d = ST_HALT;
            else if (!stop_mode)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            if (crit)
               state_d = ST_HALT;
            else if (stop_mode)
               state_d = ST_IDLE;
         end
         ST_HALT: if (release_w) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 3'h0;
         tmo_q  <= TMO_RST;
         mask_q <= MASK_RST;
      end else begin
         if (wr_ctrl)
            ctrl_q <= {1'b0, bus.wdata[1:0]};
         if (wr_tmo)
            tmo_q <= clamp_tmo(bus.wdata);
         if (wr_mask)
            mask_q <= bus.wdata[EV_N-1:0];
      end
   end

   // ************************************************************
   // Status and error flag words
   // ************************************************************
   // Entry into halt, from run or from idle
   wire halt_entry = (state_d == ST_HALT) && (state_q != ST_HALT);

   // Set wins over write one to clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat_q     <= '0;
         err_code_q <= CODE_NONE;
         min_code_q <= CODE_NONE;
      end else begin
         stat_q <= (stat_q & ~(wr_stat ? bus.wdata[EV_N-1:0] : '0)) | ev;
         if (halt_entry)
            err_code_q <= crit_code;
         else if (release_w && state_q == ST_HALT)
            err_code_q <= CODE_NONE;
         if (minor)
            min_code_q <= minor_code;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         run_enable       <= 1'b0;
         outputs_off      <= 1'b1;
         error_lamp       <= 1'b0;
         backup_cell_lamp <= 1'b0;
         irq              <= 1'b0;
      end else begin
         run_enable       <= (state_d == ST_RUN);
         outputs_off      <= (state_d != ST_RUN);
         error_lamp       <= (state_d == ST_HALT);
         backup_cell_lamp <= batt_low;
         irq              <= |(stat_q & mask_q);
      end
   end

   // Read data, one cycle after the strobe
   wire [15:0] rd_mux =
      (bus.addr == ADR_CTRL) ? {13'h0, ctrl_q} :
      (bus.addr == ADR_TMO)  ? {6'h00, tmo_q} :
      (bus.addr == ADR_STAT) ? {8'h00, stat_q} :
      (bus.addr == ADR_MASK) ? {8'h00, mask_q} :
      (bus.addr == ADR_ERR)  ? err_code_q :
      (bus.addr == ADR_MIN)  ? min_code_q :
      (bus.addr == ADR_CNT)  ? {5'h00, wdt_cnt_q} : 16'h0000;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         rdata <= 16'h0000;
      else
         rdata <= bus.rd ? rd_mux : 16'h0000;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_expire_halts;
      @(posedge mclk) disable iff (rst)
      wdt_expire |=> (state_q == ST_HALT && outputs_off && error_lamp);
   endproperty
   a_expire_halts: assert property (p_expire_halts) else $error("expiry not halting");

   property p_lamp_holds;
      @(posedge mclk) disable iff (rst)
      (error_lamp && !release_w && state_q == ST_HALT) |=> error_lamp;
   endproperty
   a_lamp_holds: assert property (p_lamp_holds) else $error("error lamp dropped");

   property p_release;
      @(posedge mclk) disable iff (rst)
      (state_q == ST_HALT && release_w) |=> (state_q == ST_IDLE);
   endproperty
   a_release: assert property (p_release) else $error("halt not released");

   property p_restart;
      @(posedge mclk) disable iff (rst)
      (running && wdt_restart) |=> (wdt_cnt_q == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("count not restarted");

   property p_tmo_range;
      @(posedge mclk) disable iff (rst)
      (tmo_q >= TMO_W'(TMO_MIN_MS)) && (tmo_q <= TMO_W'(TMO_MAX_MS));
   endproperty
   a_tmo_range: assert property (p_tmo_range) else $error("timeout out of range");

   property p_io_stop;
      @(posedge mclk) disable iff (rst)
      (running && io_bad) |=> (error_lamp && !run_enable);
   endproperty
   a_io_stop: assert property (p_io_stop) else $error("module fault not stopping");

   property p_batt_lamp;
      @(posedge mclk) disable iff (rst)
      batt_low |=> backup_cell_lamp;
   endproperty
   a_batt_lamp: assert property (p_batt_lamp) else $error("battery lamp off");

   property p_minor_runs;
      @(posedge mclk) disable iff (rst)
      (running && !crit && !stop_mode && prog.ext_minor) |=> running;
   endproperty
   a_minor_runs: assert property (p_minor_runs) else $error("minor fault stopped run");

   property p_code_saved;
      @(posedge mclk) disable iff (rst)
      (running && ev[EV_CFG] && !ev[EV_WDT] && !ev[EV_HWCRIT] && !ev[EV_IOMOD])
         |=> (err_code_q == CODE_CFG);
   endproperty
   a_code_saved: assert property (p_code_saved) else $error("code not stored");

   property p_idle_fault;
      @(posedge mclk) disable iff (rst)
      (state_q == ST_IDLE && !stop_mode && crit) |=> (state_q == ST_HALT && error_lamp);
   endproperty
   a_idle_fault: assert property (p_idle_fault) else $error("idle fault not halting");

   property p_halt_off;
      @(posedge mclk) disable iff (rst)
      (state_q != ST_RUN) |-> (outputs_off && !run_enable);
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("outputs on while stopped");

   property p_minor_code;
      @(posedge mclk) disable iff (rst)
      ev[EV_BATT] |=> (min_code_q == CODE_BATT);
   endproperty
   a_minor_code: assert property (p_minor_code) else $error("minor code not stored");

   property p_set_sticks;
      @(posedge mclk) disable iff (rst)
      ev[EV_BATT] |=> stat_q[EV_BATT];
   endproperty
   a_set_sticks: assert property (p_set_sticks) else $error("status bit lost");

   property p_arith_stop;
      @(posedge mclk) disable iff (rst)
      (running && prog.arith_err && ctrl_q[CTL_ARITH_STOP]) |=> (state_q == ST_HALT);
   endproperty
   a_arith_stop: assert property (p_arith_stop) else $error("arith stop ignored");

   property p_ext_crit_stop;
      @(posedge mclk) disable iff (rst)
      (running && prog.ext_crit) |=> (state_q == ST_HALT && error_lamp);
   endproperty
   a_ext_crit_stop: assert property (p_ext_crit_stop) else $error("external fault ran on");

   property p_hw_crit_stop;
      @(posedge mclk) disable iff (rst)
      (running && hw_bad && !wdt_expire) |=> (state_q == ST_HALT && err_code_q == CODE_HWCRIT);
   endproperty
   a_hw_crit_stop: assert property (p_hw_crit_stop) else $error("hardware fault ran on");

   property p_no_self_release;
      @(posedge mclk) disable iff (rst)
      (state_q == ST_HALT && !release_w) |=> (state_q == ST_HALT);
   endproperty
   a_no_self_release: assert property (p_no_self_release) else $error("halt left alone");

endmodule : swd_core

`default_nettype wire

// [core/swd_pkg.sv]
package swd_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int  CLK_HZ          = 40000000;
   localparam int  TICK_MS         = 1;
   localparam int  TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int  TMO_MIN_MS      = 10;
   localparam int  TMO_MAX_MS      = 1000;
   localparam int  TMO_W           = 10;

   // ************************************************************
   // Register map (word addresses)
   // ************************************************************
   localparam int  ADDR_W          = 4;
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_TMO  = 4'h1;
   localparam logic [3:0] ADR_STAT = 4'h2;
   localparam logic [3:0] ADR_MASK = 4'h3;
   localparam logic [3:0] ADR_ERR  = 4'h4;
   localparam logic [3:0] ADR_MIN  = 4'h5;
   localparam logic [3:0] ADR_CNT  = 4'h6;

   // Control bit positions
   localparam int  CTL_ARITH_STOP  = 0;
   localparam int  CTL_STOP_MODE   = 1;
   localparam int  CTL_MAN_RESET   = 2;

   // Reset values
   localparam logic [9:0]  TMO_RST  = 10'h0C8;
   localparam logic [7:0]  MASK_RST = 8'h00;

   // Event / status bit positions
   localparam int  EV_WDT    = 0;
   localparam int  EV_IOMOD  = 1;
   localparam int  EV_CFG    = 2;
   localparam int  EV_BATT   = 3;
   localparam int  EV_HWCRIT = 4;
   localparam int  EV_ARITH  = 5;
   localparam int  EV_EXTCR  = 6;
   localparam int  EV_EXTMN  = 7;
   localparam int  EV_N      = 8;

   // Error codes stored in the flag words
   localparam logic [15:0] CODE_NONE   = 16'h0000;
   localparam logic [15:0] CODE_WDT    = 16'h0021;
   localparam logic [15:0] CODE_IOMOD  = 16'h0011;
   localparam logic [15:0] CODE_CFG    = 16'h0012;
   localparam logic [15:0] CODE_BATT   = 16'h0500;
   localparam logic [15:0] CODE_HWCRIT = 16'h0002;
   localparam logic [15:0] CODE_ARITH  = 16'h0501;
   localparam logic [15:0] CODE_EXTCR  = 16'h0033;
   localparam logic [15:0] CODE_EXTMN  = 16'h0502;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } swd_bus_type;

   typedef struct packed {
      logic scan_end;
      logic wdt_clear;
      logic ext_crit;
      logic ext_minor;
      logic arith_err;
   } swd_prog_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RUN   = 3'b010,
      ST_HALT  = 3'b100
   } swd_state_type;

endpackage : swd_pkg

// [test/swd_partner.sv]
`timescale 1ns/1ps
`default_nettype none

module swd_partner
   import swd_pkg::*;
#(
   parameter int GAP = 24
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Controls from the bench
   input  wire logic        scan_on,
   input  wire logic        clr_on,
   input  wire logic [4:0]  fault_lvl,
   input  wire logic [2:0]  ev_req,
   // Towards the block
   output var swd_prog_type prog,
   output logic [4:0]       pins
);
   logic [7:0] gap_q;

   // ************************************************************
   // Scan sequencer
   // ************************************************************
   // Scan end or mid-scan clear every GAP cycles, program events registered from ev_req and held as long as it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gap_q <= 8'h00;
         prog  <= '0;
      end else begin
         gap_q          <= (gap_q == 8'(GAP - 1)) ? 8'h00 : gap_q + 8'h01;
         prog.scan_end  <= scan_on && (gap_q == 8'(GAP - 1));
         prog.wdt_clear <= clr_on && (gap_q == 8'(GAP - 1));
         prog.ext_crit  <= ev_req[0];
         prog.ext_minor <= ev_req[1];
         prog.arith_err <= ev_req[2];
      end
   end

   // Installed module status lines, held as levels
   assign pins = fault_lvl;

endmodule : swd_partner

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import swd_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   logic         mclk;
   logic         rst;
   swd_bus_type  bus;
   logic [15:0]  rdata;
   swd_prog_type prog;
   logic [4:0]   pins;
   logic         run_enable, outputs_off, error_lamp, backup_cell_lamp, irq;
   logic         scan_on, clr_on;
   logic [4:0]   fault_lvl;
   logic [2:0]   ev_req;
   int           err_total, tests_run, cyc, n;

   swd_core #(.TICK_CYC(4)) swd_core_i (
      .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .prog(prog),
      .io_mismatch_pin(pins[0]), .io_fail_pin(pins[1]), .cfg_mismatch_pin(pins[2]),
      .batt_low_pin(pins[3]), .hw_crit_pin(pins[4]), .run_enable(run_enable),
      .outputs_off(outputs_off), .error_lamp(error_lamp),
      .backup_cell_lamp(backup_cell_lamp), .irq(irq));

   swd_partner #(.GAP(24)) swd_partner_i (
      .mclk(mclk), .rst(rst), .scan_on(scan_on), .clr_on(clr_on),
      .fault_lvl(fault_lvl), .ev_req(ev_req), .prog(prog), .pins(pins));

   // ************************************************************
   // Clock and hang guard
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Cycle ceiling well above the expected run length
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         wrap_up();
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         err_total = err_total + 1;
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input string name, input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd

   task automatic settle(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : settle

   // Run state outputs as one 3-bit word: run, outputs off, error lamp
   task automatic chk_state(input string name, input logic [2:0] exp);
      chk(name, {13'h0000, exp}, {13'h0000, run_enable, outputs_off, error_lamp});
   endtask : chk_state

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // Main sequence
   // ************************************************************
   logic [2:0]  cp_idx [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   logic [15:0] cp_code [4] = '{CODE_IOMOD, CODE_IOMOD, CODE_CFG, CODE_HWCRIT};
   int          cp_bit [4] = '{EV_IOMOD, EV_IOMOD, EV_CFG, EV_HWCRIT};

   initial begin
      err_total = 0;
      tests_run = 0;
      cyc       = 0;
      rst       = 1'b1;
      bus       = '0;
      scan_on   = 1'b1;
      clr_on    = 1'b0;
      fault_lvl = 5'h00;
      ev_req    = 3'h0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      settle(3);
      // Reset values and unmapped address
      chk_state("run_after_reset", 3'b100);
      rd("tmo_reset", ADR_TMO, 16'h00C8);
      rd("mask_reset", ADR_MASK, 16'h0000);
      rd("unmapped", 4'hF, 16'h0000);
      // Timeout clamped to the documented range
      wr(ADR_TMO, 16'h0005);
      rd("tmo_low_clamp", ADR_TMO, 16'h000A);
      wr(ADR_TMO, 16'h03E9);
      rd("tmo_high_clamp", ADR_TMO, 16'h03E8);
      wr(ADR_TMO, 16'h000A);
      // Scan ends, then program clears, keep the watchdog quiet
      settle(200);
      chk_state("scan_end_keeps_run", 3'b100);
      scan_on <= 1'b0;
      clr_on  <= 1'b1;
      settle(200);
      chk_state("clear_keeps_run", 3'b100);
      // Expiry timed from the last clear
      @(posedge mclk iff prog.wdt_clear);
      clr_on <= 1'b0;
      n = 0;
      while (run_enable === 1'b1 && n < 80) begin
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      chk("expiry_cycles", 16'h0001, {15'h0000, (n > 40 && n <= 52)});
      chk_state("expiry_halt", 3'b011);
      rd("expiry_code", ADR_ERR, CODE_WDT);
      rd("expiry_stat", ADR_STAT, 16'h0001);
      // Scan ends alone never release the error
      scan_on <= 1'b1;
      settle(150);
      chk_state("lamp_holds", 3'b011);
      rd("cnt_halted", ADR_CNT, 16'h0000);
      wr(ADR_CTRL, 16'h0004);
      settle(4);
      chk_state("manual_release", 3'b100);
      rd("err_cleared", ADR_ERR, CODE_NONE);
      // Second expiry released by stop mode
      scan_on <= 1'b0;
      settle(80);
      chk_state("second_expiry", 3'b011);
      wr(ADR_CTRL, 16'h0002);
      settle(4);
      chk_state("stop_release", 3'b010);
      scan_on <= 1'b1;
      wr(ADR_CTRL, 16'h0000);
      settle(4);
      chk_state("rerun", 3'b100);
      // Critical pin faults stop and record their codes
      for (int i = 0; i < 4; i++) begin
         wr(ADR_STAT, 16'h00FF);
         fault_lvl <= 5'h01 << cp_idx[i];
         settle(8);
         chk_state("pin_fault_halt", 3'b011);
         rd("pin_fault_code", ADR_ERR, cp_code[i]);
         rd("pin_fault_stat", ADR_STAT, 16'h0001 << cp_bit[i]);
         wr(ADR_CTRL, 16'h0004);
         settle(4);
         chk_state("fault_persists", 3'b011);
         fault_lvl <= 5'h00;
         settle(4);
         wr(ADR_CTRL, 16'h0004);
         settle(4);
         chk_state("pin_fault_release", 3'b100);
      end
      // Low battery is minor: lamp on, running on, interrupt path
      wr(ADR_STAT, 16'h00FF);
      fault_lvl <= 5'h08;
      settle(8);
      chk("batt_lamp", 16'h0001, {15'h0000, backup_cell_lamp});
      chk_state("batt_runs", 3'b100);
      rd("batt_code", ADR_MIN, CODE_BATT);
      chk("irq_masked", 16'h0000, {15'h0000, irq});
      wr(ADR_MASK, 16'h0008);
      settle(3);
      chk("irq_unmasked", 16'h0001, {15'h0000, irq});
      fault_lvl <= 5'h00;
      settle(4);
      wr(ADR_STAT, 16'h0008);
      settle(3);
      chk("irq_cleared", 16'h0000, {15'h0000, irq});
      rd("stat_cleared", ADR_STAT, 16'h0000);
      // Program events: arith and ext minor continue, ext crit stops
      ev_req <= 3'h4;
      @(posedge mclk);
      ev_req <= 3'h0;
      settle(4);
      chk_state("arith_runs", 3'b100);
      rd("arith_code", ADR_MIN, CODE_ARITH);
      ev_req <= 3'h2;
      @(posedge mclk);
      ev_req <= 3'h0;
      settle(4);
      chk_state("ext_minor_runs", 3'b100);
      rd("ext_minor_stat", ADR_STAT, 16'h00A0);
      ev_req <= 3'h1;
      @(posedge mclk);
      ev_req <= 3'h0;
      settle(4);
      chk_state("ext_crit_halt", 3'b011);
      rd("ext_crit_code", ADR_ERR, CODE_EXTCR);
      wr(ADR_CTRL, 16'h0005);
      settle(4);
      rd("ctrl_read", ADR_CTRL, 16'h0001);
      // Arith error made critical by the control bit
      ev_req <= 3'h4;
      @(posedge mclk);
      ev_req <= 3'h0;
      settle(4);
      chk_state("arith_stop", 3'b011);
      rd("arith_crit_code", ADR_ERR, CODE_ARITH);
      wrap_up();
   end

endmodule : testbench

`default_nettype wire
